/* File: design/adcs_defines.svh */
`ifndef ADCS_DEFINES_SVH
`define ADCS_DEFINES_SVH
// How it works
// [R1] Two result bits per clock, six clocks.
// [R2] Pair config bit: 0 single-ended, 1 differential.
// [R3] Differential: even to plus, odd to minus.
// [R4] Result is 12 bits shifted left three.
// [R5] Slot offset subtracted, stored in slot result.
// [R6] Limits on raw, zero crossing on result.
// [R7] Sign comes from raw minus offset.
// [R8] Idle test writes run through processing path only while stop A is set or powered down.
// [R9] Test data supplied left-justified, without sign.
// [R10] Eight slots from list, disabled slots unused.
// [R11] Either pair member gives differential measurement.
// [R12] Sequential mode converts slots 0 to 7.
// [R13] Start bit or enabled sync edge starts.
// [R14] Scan ends at first disabled slot; event.
// [R15] Starts and syncs ignored during a scan.
// [R16] Stop halts scan and blocks new starts.
// [R17] Parallel: A slots 0-3, B 4-7.
// [R18] Simultaneous: lockstep, shared controls, joint end.
// [R19] Non-simultaneous: separate controls per converter.
// [R20] Non-simultaneous: each ends in own half.
// [R21] Non-simultaneous: each stop halts own converter.
// [R22] Non-simultaneous loops restart independently.
// [R23] Once mode ignores sync until re-armed.
// [R24] Loop restarts at once until stopped.
// [R25] In-progress flag spans start to end.
`define ADCS_RAW_W 12
`define ADCS_RES_W 16
`define ADCS_JUSTIFY 3
`define ADCS_BITS_PER_CLK 2
`define ADCS_CONV_CLKS (`ADCS_RAW_W / `ADCS_BITS_PER_CLK)
`define ADCS_SAMPLE_CLKS 1
`define ADCS_SLOTS 8
`define ADCS_HALF_SLOTS 4
`define ADCS_SCAN_MODE_FIELD_PAR_BIT 2
`define ADCS_STATE_RST '0
`define ADCS_ARMED_RST 2'h3
`endif

/* File: design/adcs_pkg.sv */
package adcs_pkg;
  `include "adcs_defines.svh"

  typedef enum logic [1:0] {
    ADCS_CV_IDLE = 2'b00,
    ADCS_CV_SAMPLE = 2'b01,
    ADCS_CV_RESOLVE = 2'b10
  } adcs_cv_state_t;

  typedef enum logic [1:0] {
    ADCS_REP_ONCE = 2'b00,
    ADCS_REP_TRIG = 2'b01,
    ADCS_REP_LOOP = 2'b10
  } adcs_rep_t;

  typedef struct packed {
    logic sample;
    logic resolve;
    logic [2:0] plus_sel;
    logic [2:0] minus_sel;
    logic minus_refl;
  } adcs_core_t;

  typedef struct packed {
    adcs_cv_state_t st;
    logic [2:0] cnt;
    logic [`ADCS_RAW_W-1:0] acc;
    logic done;
    logic [`ADCS_RAW_W-1:0] raw;
    adcs_core_t core;
  } adcs_cv_t;

  typedef struct packed {
    logic [1:0] scanning;
    logic [1:0][2:0] slot;
    logic [1:0] go;
    logic [1:0] armed;
    logic [1:0] sync_prev;
    logic [1:0] eos;
    logic limit_ev;
    logic zc_ev;
    logic [`ADCS_SLOTS-1:0][`ADCS_RES_W-1:0] result;
  } adcs_state_t;
endpackage

/* File: design/adcs_conv.sv */
`timescale 1ns/1ps
`include "adcs_defines.svh"
module adcs_conv
  import adcs_pkg::*;
#(
  parameter int RAW_W = `ADCS_RAW_W
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic i_go,
  input wire logic i_abort,
  input wire logic [2:0] i_sel,
  input wire logic [3:0] i_pair_cfg,
  input wire logic [1:0] i_bits,
  output adcs_core_t o_core,
  output logic o_done,
  output logic [`ADCS_RAW_W-1:0] o_raw
);
  if (RAW_W != `ADCS_RAW_W || (RAW_W % `ADCS_BITS_PER_CLK) != 0) begin : g_chk
    $error("adcs_conv: unsupported raw width");
  end

  adcs_cv_t q;
  adcs_cv_t d;
  logic diff;

  always_comb begin
    d = q;
    d.done = 1'b0;
    diff = i_pair_cfg[i_sel[2:1]]; // [R2] [R11]
    case (q.st)
      ADCS_CV_IDLE: begin
        if (i_go) begin
          d.core.plus_sel = diff ? {i_sel[2:1], 1'b0} : i_sel; // [R3]
          d.core.minus_sel = {i_sel[2:1], 1'b1}; // [R3]
          d.core.minus_refl = ~diff; // [R3]
          d.core.sample = 1'b1;
          d.cnt = 3'(`ADCS_SAMPLE_CLKS - 1);
          d.st = ADCS_CV_SAMPLE;
        end
      end
      ADCS_CV_SAMPLE: begin
        if (q.cnt == 3'h0) begin
          d.core.sample = 1'b0;
          d.core.resolve = 1'b1;
          d.acc = '0;
          d.cnt = 3'(`ADCS_CONV_CLKS - 1); // [R1]
          d.st = ADCS_CV_RESOLVE;
        end else begin
          d.cnt = 3'(q.cnt - 3'h1);
        end
      end
      ADCS_CV_RESOLVE: begin
        d.acc = {q.acc[RAW_W-3:0], i_bits}; // [R1]
        if (q.cnt == 3'h0) begin
          d.raw = {q.acc[RAW_W-3:0], i_bits}; // [R1]
          d.done = 1'b1;
          d.core.resolve = 1'b0;
          d.st = ADCS_CV_IDLE;
        end else begin
          d.cnt = 3'(q.cnt - 3'h1);
        end
      end
      default: begin
        d.st = ADCS_CV_IDLE;
      end
    endcase
    if (i_abort) begin
      d.st = ADCS_CV_IDLE;
      d.core.sample = 1'b0;
      d.core.resolve = 1'b0;
      d.done = 1'b0;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      q <= `ADCS_STATE_RST;
    end else if (i_ce) begin
      q <= d;
    end
  end

  assign o_core = q.core;
  assign o_done = q.done;
  assign o_raw = q.raw;
endmodule

/* File: design/adcs_top.sv */
`timescale 1ns/1ps
`include "adcs_defines.svh"
module adcs_top
  import adcs_pkg::*;
#(
  parameter int SLOTS = `ADCS_SLOTS
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic i_ce,
  input wire logic [2:0] i_scan_mode_field,
  input wire logic i_simultaneous_select,
  input wire logic [3:0] i_pair_config_field,
  input wire logic i_start_bit_a,
  input wire logic i_start_bit_b,
  input wire logic i_stop_bit_a,
  input wire logic i_stop_bit_b,
  input wire logic i_sync_en_a,
  input wire logic i_sync_en_b,
  input wire logic i_sync_a,
  input wire logic i_sync_b,
  input wire logic i_end_of_scan_irq_en_a,
  input wire logic i_end_of_scan_irq_en_b,
  input wire logic i_control_one_wr,
  input wire logic i_control_two_wr,
  input wire logic [`ADCS_SLOTS*3-1:0] i_slot_list,
  input wire logic [`ADCS_SLOTS-1:0] i_slot_disable_reg,
  input wire logic [`ADCS_SLOTS-1:0][`ADCS_RES_W-1:0] i_offset_reg,
  input wire logic [`ADCS_RES_W-1:0] i_limit_low,
  input wire logic [`ADCS_RES_W-1:0] i_limit_high,
  input wire logic i_limit_irq_en,
  input wire logic i_zero_cross_irq_en,
  input wire logic i_powered_down,
  input wire logic i_test_wr,
  input wire logic [2:0] i_test_slot,
  input wire logic [`ADCS_RES_W-1:0] i_test_data,
  input wire logic [1:0] i_core_bits_a,
  input wire logic [1:0] i_core_bits_b,
  output adcs_core_t o_core_a,
  output adcs_core_t o_core_b,
  output logic o_in_progress_a,
  output logic o_in_progress_b,
  output logic o_end_of_scan_irq_a,
  output logic o_end_of_scan_irq_b,
  output logic o_limit_irq,
  output logic o_zero_cross_irq,
  output logic [`ADCS_SLOTS-1:0][`ADCS_RES_W-1:0] o_result_reg
);
  if (SLOTS != `ADCS_SLOTS) begin : g_chk
    $error("adcs_top: slot count must be eight");
  end

  adcs_state_t q;
  adcs_state_t d;
  logic par;
  logic simultaneous_select;
  logic indep;
  adcs_rep_t rep;
  logic [1:0] use_cv;
  logic [1:0] start;
  logic [1:0] stop;
  logic [1:0] sync_edge;
  logic [1:0] rearm;
  logic [1:0] eos_en;
  logic [1:0] trig;
  logic [1:0] empty;
  logic [1:0] at_end;
  logic [1:0] fin;
  logic [1:0][2:0] base;
  logic [1:0][2:0] last;
  logic [1:0][2:0] nxt;
  logic [1:0][2:0] sel;
  logic [1:0] abort;
  logic [1:0] cv_done;
  logic [1:0][`ADCS_RAW_W-1:0] cv_raw;
  logic [2:0] pv;
  logic [2:0][2:0] pslot;
  logic [2:0][`ADCS_RES_W-1:0] praw;
  logic [`ADCS_RES_W-1:0] res;

  always_comb begin
    par = i_scan_mode_field[`ADCS_SCAN_MODE_FIELD_PAR_BIT];
    rep = adcs_rep_t'(i_scan_mode_field[1:0]);
    simultaneous_select = par & i_simultaneous_select; // [R18]
    indep = par & ~i_simultaneous_select; // [R19]
    use_cv = {par, 1'b1};
    start[0] = i_start_bit_a; // [R13]
    start[1] = indep ? i_start_bit_b : i_start_bit_a; // [R19]
    stop[0] = i_stop_bit_a;
    stop[1] = indep ? i_stop_bit_b : i_stop_bit_a; // [R18] [R21]
    sync_edge[0] = i_sync_en_a & i_sync_a & ~q.sync_prev[0]; // [R13]
    sync_edge[1] = indep ? (i_sync_en_b & i_sync_b & ~q.sync_prev[1]) : sync_edge[0]; // [R19]
    rearm[0] = i_control_one_wr; // [R23]
    rearm[1] = indep ? i_control_two_wr : i_control_one_wr; // [R23]
    eos_en[0] = i_end_of_scan_irq_en_a; // [R14]
    eos_en[1] = indep & i_end_of_scan_irq_en_b; // [R19]
    base[0] = 3'h0;
    base[1] = 3'h4; // [R17]
    last[0] = par ? 3'h3 : 3'h7; // [R12] [R17]
    last[1] = 3'h7;
    for (int c = 0; c < 2; c++) begin
      nxt[c] = 3'(q.slot[c] + 3'h1);
      at_end[c] = (q.slot[c] == last[c]) | i_slot_disable_reg[nxt[c]]; // [R14] [R20]
      trig[c] = use_cv[c] & ~q.scanning[c] & ~stop[c] // [R15] [R16]
        & (start[c] | (sync_edge[c] & (q.armed[c] | rep != ADCS_REP_ONCE))); // [R23]
      abort[c] = q.scanning[c] & stop[c]; // [R16]
      sel[c] = par ? {c[0], i_slot_list[q.slot[c]*3 +: 2]} : i_slot_list[q.slot[c]*3 +: 3]; // [R10] [R17]
    end
    empty[0] = simultaneous_select ? (i_slot_disable_reg[0] | i_slot_disable_reg[4]) : i_slot_disable_reg[0]; // [R18]
    empty[1] = simultaneous_select ? empty[0] : i_slot_disable_reg[4];
    fin[0] = simultaneous_select ? (at_end[0] | at_end[1]) : at_end[0]; // [R18] [R20]
    fin[1] = simultaneous_select ? fin[0] : at_end[1];
  end

  always_comb begin
    pv = {i_test_wr & ~|q.scanning & (i_stop_bit_a | i_powered_down), // [R8]
          cv_done[1] & q.scanning[1] & ~abort[1], cv_done[0] & q.scanning[0] & ~abort[0]}; // [R16]
    pslot = {i_test_slot, q.slot[1], q.slot[0]}; // [R5]
    praw[0] = {1'b0, cv_raw[0], 3'h0}; // [R4]
    praw[1] = {1'b0, cv_raw[1], 3'h0}; // [R4]
    praw[2] = {1'b0, i_test_data[14:3], 3'h0}; // [R8] [R9]
  end

  always_comb begin
    d = q;
    d.go = '0;
    d.eos = '0;
    d.limit_ev = 1'b0;
    d.zc_ev = 1'b0;
    res = '0;
    d.sync_prev = {i_sync_b, i_sync_a};
    for (int k = 0; k < 3; k++) begin
      if (pv[k]) begin
        res = 16'(praw[k] - i_offset_reg[pslot[k]]); // [R5] [R7]
        d.result[pslot[k]] = res; // [R5]
        if (i_limit_irq_en && ($signed(praw[k]) > $signed(i_limit_high)
            || $signed(praw[k]) < $signed(i_limit_low))) begin
          d.limit_ev = 1'b1; // [R6]
        end
        if (i_zero_cross_irq_en && (res[15] != q.result[pslot[k]][15])) begin
          d.zc_ev = 1'b1; // [R6]
        end
      end
    end
    for (int c = 0; c < 2; c++) begin
      if (trig[c]) begin
        if (sync_edge[c] && !start[c] && rep == ADCS_REP_ONCE) begin
          d.armed[c] = 1'b0; // [R23]
        end
        if (empty[c]) begin
          d.eos[c] = eos_en[c]; // [R14]
        end else begin
          d.scanning[c] = 1'b1; // [R25]
          d.slot[c] = base[c]; // [R12] [R17]
          d.go[c] = 1'b1;
        end
      end else if (abort[c]) begin
        d.scanning[c] = 1'b0; // [R16] [R25]
      end else if (!use_cv[c]) begin
        d.scanning[c] = 1'b0;
      end else if (q.scanning[c] && cv_done[c]) begin
        if (fin[c]) begin
          d.eos[c] = eos_en[c]; // [R14]
          if (rep == ADCS_REP_LOOP) begin
            d.slot[c] = base[c]; // [R22] [R24]
            d.go[c] = 1'b1;
          end else begin
            d.scanning[c] = 1'b0; // [R25]
          end
        end else begin
          d.slot[c] = nxt[c]; // [R12]
          d.go[c] = 1'b1;
        end
      end
      if (rearm[c]) begin
        d.armed[c] = 1'b1; // [R23]
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      q <= `ADCS_STATE_RST;
      q.armed <= `ADCS_ARMED_RST;
    end else if (i_ce) begin
      q <= d;
    end
  end

  adcs_conv #(
    .RAW_W(`ADCS_RAW_W)
  ) u_conv_a (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_go(q.go[0]),
    .i_abort(abort[0]),
    .i_sel(sel[0]),
    .i_pair_cfg(i_pair_config_field),
    .i_bits(i_core_bits_a),
    .o_core(o_core_a),
    .o_done(cv_done[0]),
    .o_raw(cv_raw[0])
  );

  adcs_conv #(
    .RAW_W(`ADCS_RAW_W)
  ) u_conv_b (
    .i_clk_sys(i_clk_sys),
    .i_rstn(i_rstn),
    .i_ce(i_ce),
    .i_go(q.go[1]),
    .i_abort(abort[1]),
    .i_sel(sel[1]),
    .i_pair_cfg(i_pair_config_field),
    .i_bits(i_core_bits_b),
    .o_core(o_core_b),
    .o_done(cv_done[1]),
    .o_raw(cv_raw[1])
  );

  assign o_in_progress_a = q.scanning[0];
  assign o_in_progress_b = q.scanning[1];
  assign o_end_of_scan_irq_a = q.eos[0];
  assign o_end_of_scan_irq_b = q.eos[1];
  assign o_limit_irq = q.limit_ev;
  assign o_zero_cross_irq = q.zc_ev;
  assign o_result_reg = q.result;
endmodule

/* File: tb/adcs_core_model.sv */
`timescale 1ns/1ps
module adcs_core_model
  import adcs_pkg::*;
(
  input wire logic i_clk_sys,
  input wire adcs_core_t i_core,
  output logic [1:0] o_bits
);
  logic [11:0] val_q;
  logic [2:0] idx_q;
  logic tog_q;
  initial tog_q = 1'b0;
  always @(posedge i_clk_sys) begin
    tog_q <= ~tog_q;
    if (i_core.sample) begin
      val_q <= {i_core.plus_sel, i_core.minus_refl, i_core.minus_refl ? 3'h0 : i_core.minus_sel, 5'h0B};
      idx_q <= 3'h0;
    end else if (i_core.resolve) begin
      idx_q <= idx_q + 3'h1;
    end
  end
  // Two bits per resolving clock, top pair first; a toggling pattern otherwise.
  assign o_bits = i_core.resolve ? val_q[11 - 2 * idx_q -: 2] : {tog_q, ~tog_q};
endmodule

/* File: tb/adcs_top_sva.sv */
`timescale 1ns/1ps
module adcs_top_sva
  import adcs_pkg::*;
#(
  parameter int SLOTS = 8
) (
  input wire logic i_clk_sys,
  input wire logic i_rstn,
  input wire logic [2:0] i_scan_mode_field,
  input wire logic i_simultaneous_select,
  input wire logic [3:0] i_pair_config_field,
  input wire logic i_start_bit_a,
  input wire logic i_stop_bit_a,
  input wire logic [7:0] i_slot_disable_reg,
  input wire logic i_end_of_scan_irq_en_a,
  input wire logic i_test_wr,
  input wire logic [2:0] i_test_slot,
  input wire logic [15:0] i_test_data,
  input wire logic [7:0][15:0] i_offset_reg,
  input wire adcs_core_t o_core_a,
  input wire adcs_core_t o_core_b,
  input wire logic o_in_progress_a,
  input wire logic o_in_progress_b,
  input wire logic o_end_of_scan_irq_a,
  input wire logic [7:0][15:0] o_result_reg
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rstn);
  sequence conv_s;
    o_core_a.resolve [*6] ##1 !o_core_a.resolve;
  endsequence
  conv_len_a: assert property (disable iff (!i_rstn || i_stop_bit_a) o_core_a.sample |=> conv_s)
    else $error("Bad conversion length.");
  diff_route_a: assert property (o_core_a.sample && i_pair_config_field[o_core_a.plus_sel[2:1]] |->
    !o_core_a.minus_refl && !o_core_a.plus_sel[0] && o_core_a.minus_sel == (o_core_a.plus_sel | 3'h1))
    else $error("Bad differential routing.");
  single_route_a: assert property (o_core_a.sample && !i_pair_config_field[o_core_a.plus_sel[2:1]] |-> o_core_a.minus_refl)
    else $error("Bad single routing.");
  half_split_a: assert property (o_core_a.sample && i_scan_mode_field[2] |-> !o_core_a.plus_sel[2] &&
    (!i_simultaneous_select || o_core_b.sample && o_core_b.plus_sel[2])) else $error("Bad parallel split.");
  start_go_a: assert property (i_start_bit_a && !o_in_progress_a && !i_stop_bit_a && !i_slot_disable_reg[0]
    && !(i_scan_mode_field[2] && i_simultaneous_select && i_slot_disable_reg[4])
    |=> o_in_progress_a) else $error("Start not taken.");
  stop_halt_a: assert property (i_stop_bit_a |=> !o_in_progress_a) else $error("Stop not obeyed.");
  busy_span_a: assert property (o_core_a.sample || o_core_a.resolve |-> o_in_progress_a)
    else $error("Converting while idle.");
  eos_end_a: assert property ($fell(o_in_progress_a) && !$past(i_stop_bit_a) && i_end_of_scan_irq_en_a
    |-> o_end_of_scan_irq_a) else $error("Missing scan end event.");
  test_wr_a: assert property (i_test_wr && i_stop_bit_a && !o_in_progress_a && !o_in_progress_b
    && i_test_data[2:0] == 3'h0 && !i_test_data[15]
    |=> o_result_reg[$past(i_test_slot)] == $past(i_test_data) - $past(i_offset_reg[i_test_slot]))
    else $error("Bad test write result.");
endmodule
bind adcs_top adcs_top_sva #(.SLOTS(SLOTS)) chk (.*);

/* File: tb/adcs_top_test.sv */
`timescale 1ns/1ps
module adcs_top_test;
  import adcs_pkg::*;
  logic i_clk_sys, i_rstn, i_ce, i_simultaneous_select, i_start_bit_a, i_start_bit_b, i_stop_bit_a, i_stop_bit_b;
  logic i_sync_en_a, i_sync_en_b, i_sync_a, i_sync_b, i_end_of_scan_irq_en_a, i_end_of_scan_irq_en_b, i_test_wr;
  logic i_control_one_wr, i_control_two_wr, i_limit_irq_en, i_zero_cross_irq_en, i_powered_down, lim_e;
  logic o_in_progress_a, o_in_progress_b, o_end_of_scan_irq_a, o_end_of_scan_irq_b, o_limit_irq, o_zero_cross_irq;
  logic [2:0] i_scan_mode_field, i_test_slot;
  logic [3:0] i_pair_config_field;
  logic [23:0] i_slot_list;
  logic [7:0] i_slot_disable_reg;
  logic [7:0][15:0] i_offset_reg, o_result_reg, old;
  logic [15:0] i_limit_low, i_limit_high, i_test_data, exp_t;
  logic [1:0] i_core_bits_a, i_core_bits_b;
  adcs_core_t o_core_a, o_core_b;
  int bad_count = 0, cmp_count = 0, cyc = 0, eos_cnt = 0, eb_cnt = 0, wk, na, nb, n, seed = 32'h9F91;
  adcs_top dut (.*);
  adcs_core_model model_a (.i_clk_sys(i_clk_sys), .i_core(o_core_a), .o_bits(i_core_bits_a));
  adcs_core_model model_b (.i_clk_sys(i_clk_sys), .i_core(o_core_b), .o_bits(i_core_bits_b));
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  always @(posedge i_clk_sys) begin
    cyc++;
    if (o_end_of_scan_irq_a === 1'b1) eos_cnt++;
    if (o_end_of_scan_irq_b === 1'b1) eb_cnt++;
    if (cyc == 20000) begin
      bad_count++;
      complete_run;
    end
  end
  task automatic complete_run;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic pulse(ref logic s);
    s = 1'b1;
    @(negedge i_clk_sys);
    s = 1'b0;
  endtask
  task automatic wait_idle;
    wk = 0;
    while ((o_in_progress_a | o_in_progress_b) !== 1'b0 && wk < 300) begin
      @(negedge i_clk_sys);
      wk++;
    end
    @(negedge i_clk_sys);
  endtask
  function automatic logic [15:0] exp_res(input int j, input logic par);
    logic [2:0] s;
    logic [11:0] r;
    s = i_slot_list[3*j +: 3];
    if (par) s = {j > 3, s[1:0]};
    r = i_pair_config_field[s[2:1]] ? {s[2:1], 2'h0, s[2:1], 1'b1, 5'h0B} : {s, 4'h8, 5'h0B};
    exp_res = {1'b0, r, 3'h0} - i_offset_reg[j];
  endfunction
  task automatic setup(input logic [2:0] mode, input logic sim);
    i_scan_mode_field = mode;
    i_simultaneous_select = sim;
    i_slot_list = 24'($random(seed));
    i_pair_config_field = 4'($random(seed));
    i_slot_disable_reg = 8'($random(seed));
    {i_limit_irq_en, i_zero_cross_irq_en, i_limit_low, i_limit_high} = 34'($random(seed));
    for (int j = 0; j < 8; j++) i_offset_reg[j] = 16'($random(seed));
  endtask
  task automatic scan(input logic par, input logic sim);
    logic u;
    old = o_result_reg;
    eos_cnt = 0;
    eb_cnt = 0;
    na = 4;
    nb = 4;
    n = 8;
    for (int j = 7; j >= 0; j--) begin
      if (i_slot_disable_reg[j]) begin
        n = j;
        if (j < 4) na = j;
        else nb = j - 4;
      end
    end
    if (sim) begin
      na = (na < nb) ? na : nb;
      nb = na;
    end
    pulse(i_start_bit_a);
    if (par && !sim) pulse(i_start_bit_b);
    wait_idle;
    for (int j = 0; j < 8; j++) begin
      u = par ? ((j < 4) ? j < na : j - 4 < nb) : j < n;
      chk(o_result_reg[j], u ? exp_res(j, par) : old[j]);
    end
    chk(16'(eos_cnt), 16'h0001);
    chk(16'(eb_cnt), (par && !sim) ? 16'h0001 : 16'h0000);
  endtask
  initial begin
    i_rstn = 1'b0;
    i_ce = 1'b1;
    {i_start_bit_a, i_start_bit_b, i_stop_bit_a, i_stop_bit_b, i_sync_a, i_sync_b, i_test_wr} = '0;
    {i_sync_en_a, i_sync_en_b, i_control_one_wr, i_control_two_wr, i_powered_down, i_test_slot} = '0;
    {i_end_of_scan_irq_en_a, i_end_of_scan_irq_en_b, i_test_data} = '1;
    setup(3'h0, 1'b1);
    repeat (5) @(negedge i_clk_sys);
    i_rstn = 1'b1;
    for (int it = 0; it < 16; it++) begin
      setup({it[1], it[2] & it[0], it[0]}, ~(it[1] & it[0]));
      if (it < 3) i_slot_disable_reg = (it == 0) ? 8'h00 : ((it == 1) ? 8'h01 : 8'h08);
      scan(it[1], ~(it[1] & it[0]));
    end
    setup(3'h0, 1'b1);
    i_slot_disable_reg = 8'h02;
    pulse(i_start_bit_a);
    repeat (3) @(negedge i_clk_sys);
    pulse(i_start_bit_a);
    wait_idle;
    chk(16'(wk), 16'h0005);
    i_sync_en_a = 1'b1;
    for (int j = 0; j < 3; j++) begin
      if (j == 2) pulse(i_control_one_wr);
      pulse(i_sync_a);
      @(negedge i_clk_sys);
      chk(16'(o_in_progress_a), (j == 1) ? 16'h0000 : 16'h0001);
      wait_idle;
    end
    i_sync_en_a = 1'b0;
    i_slot_disable_reg = 8'h00;
    pulse(i_start_bit_a);
    repeat (12) @(negedge i_clk_sys);
    i_stop_bit_a = 1'b1;
    @(negedge i_clk_sys);
    pulse(i_start_bit_a);
    chk(16'(o_in_progress_a), 16'h0000);
    for (int j = 0; j < 8; j++) begin
      i_powered_down = j[0];
      i_stop_bit_a = ~j[0];
      {i_limit_irq_en, i_zero_cross_irq_en} = 2'(j >> 1);
      i_test_slot = 3'($random(seed));
      i_test_data = 16'($random(seed)) & 16'h7FF8;
      exp_t = i_test_data - i_offset_reg[i_test_slot];
      lim_e = $signed(i_test_data) > $signed(i_limit_high) | $signed(i_test_data) < $signed(i_limit_low);
      old = o_result_reg;
      pulse(i_test_wr);
      chk(o_result_reg[i_test_slot], exp_t);
      chk({15'h0, o_limit_irq}, {15'h0, i_limit_irq_en & lim_e});
      chk({15'h0, o_zero_cross_irq}, {15'h0, i_zero_cross_irq_en & (exp_t[15] ^ old[i_test_slot][15])});
    end
    i_powered_down = 1'b0;
    setup(3'h2, 1'b1);
    i_slot_disable_reg = 8'h02;
    eos_cnt = 0;
    pulse(i_start_bit_a);
    repeat (40) @(negedge i_clk_sys);
    chk(16'(eos_cnt), 16'h0004);
    i_stop_bit_a = 1'b1;
    @(negedge i_clk_sys);
    i_stop_bit_a = 1'b0;
    setup(3'h6, 1'b0);
    i_slot_disable_reg = 8'h22;
    pulse(i_start_bit_a);
    pulse(i_start_bit_b);
    i_stop_bit_b = 1'b1;
    repeat (30) @(negedge i_clk_sys);
    chk(16'({o_in_progress_a, o_in_progress_b}), 16'h0002);
    complete_run;
  end
endmodule
